// ### accumulator_alu_status.sv
// accumulator, b register, status word and internal ram behind an apb slave
// assumes an apb master on pclk; instructions are issued through the command register
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1: add takes direct byte in 2 bytes/2 cycles, register 1/1, indirect 1/2.
// RL2: carry sum adds operand plus carry; immediate form 2 bytes, 2 cycles.
// RL3: borrow subtract removes operand and carry; direct 2/2, register 1/1.
// RL4: and immediate into direct byte, result stored there; 3 bytes, 3 cycles.
// RL5: and, or, xor of indirect ram into accumulator take 1 byte, 2 cycles.
// RL6: xor direct into accumulator and accumulator into direct, both 2/2.
// RL7: xor and or of immediate into direct byte take 3 bytes, 3 cycles.
// RL8: rotate left through carry: bit 7 to carry, carry to bit 0; 1/1.
// RL9: user flags change only by software writes, never by instruction results.
// RL10: bank select bits pick one of four eight-byte register banks.
// RL11: sign wrap set on signed overflow, big product, divide by zero; else cleared.
module accumulator_alu_status #(
    parameter int RAM_DEPTH = 128
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    logic [7:0]          acc_q, acc_d;
    logic [7:0]          b_q, b_d;
    logic [7:1]          psw_q, psw_d;
    logic [7:0]          ram_q [RAM_DEPTH];
    logic [7:0]          ram_d [RAM_DEPTH];
    logic [6:0]          ram_ptr_q, ram_ptr_d;
    alu_pkg::cmd_t       cmd_q, cmd_d, cmd_in;
    logic [31:0]         prdata_q, prdata_d;

    logic                busy, finish, start;
    logic [1:0]          last_bytes;
    logic [alu_pkg::CNT_W-1:0] last_cycles;
    logic [7:0]          psw_rd, dir_val, opnd, first, ind_ptr, dest_val;
    logic [6:0]          reg_idx;
    logic                logical, dest_direct;
    alu_pkg::alu_out_t   res;

    // apb decode
    logic sel_cmd, sel_stat, sel_acc, sel_b, sel_ptr, sel_data, sel_psw;
    logic hit, guarded, cmd_ok, access, setup, err, wr;

    assign psw_rd = {psw_q, ^acc_q};

    always_comb begin
        sel_cmd  = (paddr == alu_pkg::OFS_CMD);
        sel_stat = (paddr == alu_pkg::OFS_STATUS);
        sel_acc  = (paddr == alu_pkg::OFS_ACC);
        sel_b    = (paddr == alu_pkg::OFS_BREG);
        sel_ptr  = (paddr == alu_pkg::OFS_RAM_PTR);
        sel_data = (paddr == alu_pkg::OFS_RAM_DATA);
        sel_psw  = (paddr == alu_pkg::OFS_PSW);
        hit      = sel_cmd | sel_stat | sel_acc | sel_b | sel_ptr | sel_data | sel_psw;
        guarded  = sel_cmd | sel_acc | sel_b | sel_data | sel_psw;
        cmd_in   = alu_pkg::cmd_t'(pwdata[23:0]);
        cmd_ok   = 1'b0;
        case (cmd_in.op)
            alu_pkg::and_op, alu_pkg::or_op, alu_pkg::xor_op:
                cmd_ok = (cmd_in.mode <= alu_pkg::mode_direct_imm);
            alu_pkg::add_op, alu_pkg::carry_sum_op, alu_pkg::borrow_subtract_op:
                cmd_ok = (cmd_in.mode <= alu_pkg::mode_immediate);
            alu_pkg::rotate_left_via_carry, alu_pkg::multiply_op, alu_pkg::divide_op:
                cmd_ok = 1'b1;
            default: cmd_ok = 1'b0;
        endcase
        access = psel & penable;
        setup  = psel & ~penable;
        // status writes are refused, since its bits reflect hardware state
        err    = access & (~hit | (pwrite & (sel_stat | (guarded & busy) | (sel_cmd & ~cmd_ok))));
        wr     = access & pwrite & ~err;
        start  = wr & sel_cmd;
    end

    assign pready  = 1'b1;
    assign pslverr = err;
    assign prdata  = prdata_q;

    // operand fetch
    always_comb begin
        reg_idx = {2'b00, psw_q[alu_pkg::RS1_BIT], psw_q[alu_pkg::RS0_BIT], cmd_q.addr[2:0]}; // RL10
        // indirect pointer register is r0 or r1 of the current bank
        ind_ptr = ram_q[{2'b00, psw_q[alu_pkg::RS1_BIT], psw_q[alu_pkg::RS0_BIT], 2'b00, cmd_q.addr[0]}]; // RL10
        if (cmd_q.addr < alu_pkg::DIR_RAM_TOP) begin
            dir_val = ram_q[cmd_q.addr[6:0]];
        end else if (cmd_q.addr == alu_pkg::DIR_PSW) begin
            dir_val = psw_rd;
        end else if (cmd_q.addr == alu_pkg::DIR_ACC) begin
            dir_val = acc_q;
        end else if (cmd_q.addr == alu_pkg::DIR_BREG) begin
            dir_val = b_q;
        end else begin
            dir_val = 8'h00;
        end
        logical = (cmd_q.op == alu_pkg::and_op) | (cmd_q.op == alu_pkg::or_op) | (cmd_q.op == alu_pkg::xor_op);
        dest_direct = logical & ((cmd_q.mode == alu_pkg::mode_direct_acc) | (cmd_q.mode == alu_pkg::mode_direct_imm));
        first = dest_direct ? dir_val : acc_q;
        case (cmd_q.mode)
            alu_pkg::mode_reg:        opnd = ram_q[reg_idx];
            alu_pkg::mode_direct:     opnd = dir_val;
            // pointers above the ram top wrap, as only the low ram is modelled
            alu_pkg::mode_indirect:   opnd = ram_q[ind_ptr[6:0]]; // RL5
            alu_pkg::mode_immediate:  opnd = cmd_q.imm;
            alu_pkg::mode_direct_acc: opnd = acc_q; // RL6
            alu_pkg::mode_direct_imm: opnd = cmd_q.imm; // RL4 RL7
            default:                  opnd = 8'h00;
        endcase
    end

    alu_core u_alu (
        .a     (first),
        .opnd  (opnd),
        .b_in  (b_q),
        .cy_in (psw_q[alu_pkg::CY_BIT]),
        .op    (cmd_q.op),
        .res   (res)
    );

    op_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (start),
        .op      (cmd_in.op),
        .mode    (cmd_in.mode),
        .busy    (busy),
        .finish  (finish),
        .bytes   (last_bytes),
        .cycles  (last_cycles)
    );

    // next state of all architectural registers
    always_comb begin
        acc_d     = acc_q;
        b_d       = b_q;
        psw_d     = psw_q;
        ram_d     = ram_q;
        ram_ptr_d = ram_ptr_q;
        cmd_d     = cmd_q;
        dest_val  = res.result;
        prdata_d  = prdata_q;
        if (setup) begin
            prdata_d = 32'h0000_0000;
            if (sel_cmd)  prdata_d = {8'h00, cmd_q};
            if (sel_stat) prdata_d = {24'h00_0000, last_cycles, last_bytes, 1'b0, busy};
            if (sel_acc)  prdata_d = {24'h00_0000, acc_q};
            if (sel_b)    prdata_d = {24'h00_0000, b_q};
            if (sel_ptr)  prdata_d = {25'h000_0000, ram_ptr_q};
            if (sel_data) prdata_d = {24'h00_0000, ram_q[ram_ptr_q]};
            if (sel_psw)  prdata_d = {24'h00_0000, psw_rd};
        end
        if (wr) begin
            if (sel_cmd)  cmd_d = cmd_in;
            if (sel_acc)  acc_d = pwdata[7:0];
            if (sel_b)    b_d = pwdata[7:0];
            if (sel_ptr)  ram_ptr_d = pwdata[6:0];
            if (sel_data) ram_d[ram_ptr_q] = pwdata[7:0];
            if (sel_psw)  psw_d = pwdata[7:1]; // RL9
        end
        // commit happens only while busy, when software writes other than the ram pointer are refused
        if (finish) begin
            if (dest_direct) begin
                if (cmd_q.addr < alu_pkg::DIR_RAM_TOP) begin
                    ram_d[cmd_q.addr[6:0]] = dest_val; // RL4 RL6 RL7
                end else if (cmd_q.addr == alu_pkg::DIR_PSW) begin
                    psw_d = (dest_val[7:1] & ~alu_pkg::USER_FLAG_MASK[7:1])
                          | (psw_q & alu_pkg::USER_FLAG_MASK[7:1]); // RL9
                end else if (cmd_q.addr == alu_pkg::DIR_ACC) begin
                    acc_d = dest_val;
                end else if (cmd_q.addr == alu_pkg::DIR_BREG) begin
                    b_d = dest_val;
                end
            end else begin
                acc_d = res.result; // RL1 RL2 RL3 RL5 RL8
                if (res.b_we) b_d = res.b_out;
                if (res.cy_we) psw_d[alu_pkg::CY_BIT] = res.cy;
                if (res.ac_we) psw_d[alu_pkg::AC_BIT] = res.ac;
                if (res.ov_we) psw_d[alu_pkg::OV_BIT] = res.ov; // RL11
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q     <= alu_pkg::ACC_RESET;
            b_q       <= alu_pkg::BREG_RESET;
            psw_q     <= alu_pkg::PSW_RESET[7:1];
            ram_ptr_q <= 7'h00;
            cmd_q     <= '0;
            prdata_q  <= 32'h0000_0000;
            for (int i = 0; i < RAM_DEPTH; i++) begin
                ram_q[i] <= 8'h00;
            end
        end else begin
            acc_q     <= acc_d;
            b_q       <= b_d;
            psw_q     <= psw_d;
            ram_ptr_q <= ram_ptr_d;
            cmd_q     <= cmd_d;
            prdata_q  <= prdata_d;
            ram_q     <= ram_d;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic is_arith_acc;
    assign is_arith_acc = finish & ~dest_direct;

    user_flags_a: assert property (($changed(psw_q[alu_pkg::F0_BIT]) || $changed(psw_q[alu_pkg::F1_BIT]))
        |-> $past(wr && sel_psw)) // RL9
        else $error("user flag changed without a status word write");
    bank_reg_a: assert property (finish && cmd_q.mode == alu_pkg::mode_reg && !dest_direct
        |-> opnd == ram_q[{2'b00, psw_q[4:3], cmd_q.addr[2:0]}]) // RL10
        else $error("register operand not taken from selected bank");
    add_reg_a: assert property (finish && cmd_q.op == alu_pkg::add_op
        |=> acc_q == 8'($past(acc_q) + $past(opnd))) // RL1
        else $error("plain sum result wrong");
    carry_sum_a: assert property (finish && cmd_q.op == alu_pkg::carry_sum_op
        |=> acc_q == 8'($past(acc_q) + $past(opnd) + {7'h00, $past(psw_q[7])})) // RL2
        else $error("carry sum result wrong");
    borrow_a: assert property (finish && cmd_q.op == alu_pkg::borrow_subtract_op
        |=> acc_q == 8'($past(acc_q) - $past(opnd) - {7'h00, $past(psw_q[7])})) // RL3
        else $error("borrow subtract result wrong");
    rotate_a: assert property (finish && cmd_q.op == alu_pkg::rotate_left_via_carry
        |=> acc_q == {$past(acc_q[6:0]), $past(psw_q[7])} && psw_q[7] == $past(acc_q[7])) // RL8
        else $error("rotate through carry wrong");
    mul_ov_a: assert property (finish && cmd_q.op == alu_pkg::multiply_op
        |=> psw_q[2] == ($past(acc_q) * $past(b_q) > 16'h00ff)) // RL11
        else $error("sign wrap flag wrong after multiply");
    div_zero_a: assert property (finish && cmd_q.op == alu_pkg::divide_op
        |=> psw_q[2] == ($past(b_q) == 8'h00)) // RL11
        else $error("sign wrap flag wrong after divide");
    xor_dir_a: assert property (finish && cmd_q.op == alu_pkg::xor_op && cmd_q.mode == alu_pkg::mode_direct_acc
        && cmd_q.addr < 8'h80 |=> ram_q[$past(cmd_q.addr[6:0])] == ($past(dir_val) ^ $past(acc_q))) // RL6
        else $error("xor of accumulator into direct byte wrong");
    and_imm_a: assert property (finish && cmd_q.op == alu_pkg::and_op && cmd_q.mode == alu_pkg::mode_direct_imm
        && cmd_q.addr < 8'h80 |=> ram_q[$past(cmd_q.addr[6:0])] == ($past(dir_val) & $past(cmd_q.imm))) // RL4
        else $error("and of immediate into direct byte wrong");

    mul_seen_c: cover property (finish && cmd_q.op == alu_pkg::multiply_op && b_q != 8'h00);
    rotate_seen_c: cover property (finish && cmd_q.op == alu_pkg::rotate_left_via_carry);
    dir_imm_seen_c: cover property (finish && cmd_q.mode == alu_pkg::mode_direct_imm && logical);
    busy_refuse_c: cover property (access && pwrite && busy && err);
endmodule
`default_nettype wire

// ### alu_core.sv
// combinational arithmetic and logic unit with flag results
// assumes operands are stable for the whole cycle in which the result is used
`timescale 1ns/1ps
`default_nettype none
module alu_core (
    input  wire logic            [7:0] a,
    input  wire logic            [7:0] opnd,
    input  wire logic            [7:0] b_in,
    input  wire logic                  cy_in,
    input  wire alu_pkg::op_t          op,
    output alu_pkg::alu_out_t          res
);
    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic [15:0] prod;
    logic        cin;

    always_comb begin
        res  = '0;
        cin  = (op == alu_pkg::add_op) ? 1'b0 : cy_in;
        sum9 = 9'h000;
        nib5 = 5'h00;
        prod = 16'h0000;
        case (op)
            alu_pkg::add_op, alu_pkg::carry_sum_op: begin
                sum9 = {1'b0, a} + {1'b0, opnd} + {8'h00, cin}; // RL1 RL2
                nib5 = {1'b0, a[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
                res.result = sum9[7:0];
                res.cy = sum9[8];
                res.ac = nib5[4];
                res.ov = (a[7] == opnd[7]) && (sum9[7] != a[7]); // RL11
                res.cy_we = 1'b1;
                res.ac_we = 1'b1;
                res.ov_we = 1'b1;
            end
            alu_pkg::borrow_subtract_op: begin
                sum9 = {1'b0, a} - {1'b0, opnd} - {8'h00, cin}; // RL3
                nib5 = {1'b0, a[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
                res.result = sum9[7:0];
                res.cy = sum9[8];
                res.ac = nib5[4];
                res.ov = (a[7] != opnd[7]) && (sum9[7] != a[7]); // RL11
                res.cy_we = 1'b1;
                res.ac_we = 1'b1;
                res.ov_we = 1'b1;
            end
            alu_pkg::and_op: res.result = a & opnd; // RL4 RL5
            alu_pkg::or_op:  res.result = a | opnd; // RL5 RL7
            alu_pkg::xor_op: res.result = a ^ opnd; // RL6 RL7
            alu_pkg::rotate_left_via_carry: begin
                res.result = {a[6:0], cy_in}; // RL8
                res.cy = a[7];
                res.cy_we = 1'b1;
            end
            alu_pkg::multiply_op: begin
                prod = a * b_in;
                res.result = prod[7:0];
                res.b_out = prod[15:8];
                res.ov = (prod[15:8] != 8'h00); // RL11
                res.cy_we = 1'b1;
                res.ov_we = 1'b1;
                res.b_we = 1'b1;
            end
            alu_pkg::divide_op: begin
                // divide by zero leaves both operands untouched
                res.result = (b_in == 8'h00) ? a : a / b_in;
                res.b_out = (b_in == 8'h00) ? b_in : a % b_in;
                res.ov = (b_in == 8'h00); // RL11
                res.cy_we = 1'b1;
                res.ov_we = 1'b1;
                res.b_we = 1'b1;
            end
            default: res = '0;
        endcase
    end
endmodule
`default_nettype wire

// ### alu_pkg.sv
// shared constants, types and register map of the accumulator datapath
// assumes an apb slave wrapper with 32-bit data and byte addresses
package alu_pkg;

    // apb byte offsets
    localparam logic [7:0] OFS_CMD      = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_ACC      = 8'h08;
    localparam logic [7:0] OFS_BREG     = 8'h0c;
    localparam logic [7:0] OFS_RAM_PTR  = 8'h10;
    localparam logic [7:0] OFS_RAM_DATA = 8'h14;
    localparam logic [7:0] OFS_PSW      = 8'hd0;

    // direct byte space seen by instructions
    localparam logic [7:0] DIR_RAM_TOP  = 8'h80;
    localparam logic [7:0] DIR_PSW      = 8'hd0;
    localparam logic [7:0] DIR_ACC      = 8'he0;
    localparam logic [7:0] DIR_BREG     = 8'hf0;

    // program_status_word fields
    localparam int CY_BIT  = 7;
    localparam int AC_BIT  = 6;
    localparam int F0_BIT  = 5;
    localparam int RS1_BIT = 4;
    localparam int RS0_BIT = 3;
    localparam int OV_BIT  = 2;
    localparam int F1_BIT  = 1;
    localparam logic [7:0] USER_FLAG_MASK = 8'h22;

    localparam logic [7:0] PSW_RESET  = 8'h00;
    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic [7:0] BREG_RESET = 8'h00;

    // status register fields
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_BYTES_LSB  = 2;
    localparam int STAT_CYCLES_LSB = 4;

    // instruction length and duration
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CYC_ONE   = 4'h1;
    localparam logic [CNT_W-1:0] CYC_TWO   = 4'h2;
    localparam logic [CNT_W-1:0] CYC_THREE = 4'h3;
    localparam logic [CNT_W-1:0] CYC_MUL   = 4'h4;
    localparam logic [CNT_W-1:0] CYC_DIV   = 4'h8;
    localparam logic [1:0] BYT_ONE   = 2'h1;
    localparam logic [1:0] BYT_TWO   = 2'h2;
    localparam logic [1:0] BYT_THREE = 2'h3;

    typedef enum logic [3:0] {
        add_op, carry_sum_op, borrow_subtract_op, and_op, or_op, xor_op,
        rotate_left_via_carry, multiply_op, divide_op
    } op_t;

    typedef enum logic [2:0] {
        mode_reg, mode_direct, mode_indirect, mode_immediate, mode_direct_acc, mode_direct_imm
    } mode_t;

    typedef struct packed {
        logic [7:0] imm;
        logic [7:0] addr;
        logic       spare;
        mode_t      mode;
        op_t        op;
    } cmd_t;

    typedef struct packed {
        logic [7:0] result;
        logic [7:0] b_out;
        logic       cy;
        logic       ac;
        logic       ov;
        logic       cy_we;
        logic       ac_we;
        logic       ov_we;
        logic       b_we;
    } alu_out_t;

endpackage

// ### op_timer.sv
// instruction length decode and cycle countdown
// assumes start is only raised while busy is low
`timescale 1ns/1ps
`default_nettype none
module op_timer (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        start,
    input  wire alu_pkg::op_t                op,
    input  wire alu_pkg::mode_t              mode,
    output logic                             busy,
    output logic                             finish,
    output logic [1:0]                       bytes,
    output logic [alu_pkg::CNT_W-1:0]        cycles
);
    logic [alu_pkg::CNT_W-1:0] cnt_q, cnt_d, cyc_dec, cyc_q, cyc_d;
    logic [1:0]                byt_dec, byt_q, byt_d;

    always_comb begin
        cyc_dec = alu_pkg::CYC_ONE;
        byt_dec = alu_pkg::BYT_ONE;
        case (op)
            alu_pkg::rotate_left_via_carry: cyc_dec = alu_pkg::CYC_ONE; // RL8
            alu_pkg::multiply_op:           cyc_dec = alu_pkg::CYC_MUL;
            alu_pkg::divide_op:             cyc_dec = alu_pkg::CYC_DIV;
            default: begin
                case (mode)
                    alu_pkg::mode_reg: cyc_dec = alu_pkg::CYC_ONE; // RL1 RL3
                    alu_pkg::mode_direct: begin
                        cyc_dec = alu_pkg::CYC_TWO; // RL1 RL3 RL6
                        byt_dec = alu_pkg::BYT_TWO;
                    end
                    alu_pkg::mode_indirect: cyc_dec = alu_pkg::CYC_TWO; // RL1 RL5
                    alu_pkg::mode_immediate, alu_pkg::mode_direct_acc: begin
                        cyc_dec = alu_pkg::CYC_TWO; // RL2 RL6
                        byt_dec = alu_pkg::BYT_TWO;
                    end
                    alu_pkg::mode_direct_imm: begin
                        cyc_dec = alu_pkg::CYC_THREE; // RL4 RL7
                        byt_dec = alu_pkg::BYT_THREE;
                    end
                    default: cyc_dec = alu_pkg::CYC_ONE;
                endcase
            end
        endcase
        cnt_d = cnt_q;
        cyc_d = cyc_q;
        byt_d = byt_q;
        if (start) begin
            cnt_d = cyc_dec;
            cyc_d = cyc_dec;
            byt_d = byt_dec;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            cyc_q <= '0;
            byt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            cyc_q <= cyc_d;
            byt_q <= byt_d;
        end
    end

    assign busy   = (cnt_q != '0);
    assign finish = (cnt_q == 4'h1);
    assign bytes  = byt_q;
    assign cycles = cyc_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    one_cycle_a: assert property (start && cyc_dec == 4'h1 |=> finish ##1 !busy) // RL1
        else $error("single cycle instruction did not finish after one cycle");
    two_cycle_a: assert property (start && cyc_dec == 4'h2 |=> !finish ##1 finish ##1 !busy) // RL5
        else $error("two cycle instruction timing wrong");
    three_cycle_a: assert property (start && cyc_dec == 4'h3 |=> busy[*2] ##1 finish ##1 !busy) // RL7
        else $error("three cycle instruction timing wrong");
    dir_imm_len_a: assert property (start && op == alu_pkg::and_op && mode == alu_pkg::mode_direct_imm
        |=> bytes == 2'h3 && cycles == 4'h3) // RL4
        else $error("and immediate to direct byte length wrong");
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for accumulator_alu_status over apb
// assumes zero-wait apb slave; commands are polled through the status busy bit
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rdat;
    logic        perr;
    int          mismatches = 0;
    int          checked = 0;
    int          i;
    alu_pkg::op_t lop [3] = '{alu_pkg::and_op, alu_pkg::or_op, alu_pkg::xor_op};
    logic [7:0]  lacc [3] = '{8'h00, 8'h21, 8'h00};

    accumulator_alu_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    // entered right after a rising edge; leaves one idle cycle behind
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask

    task automatic set_ram(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, alu_pkg::OFS_RAM_PTR, {24'h0, a});
        xfer(1'b1, alu_pkg::OFS_RAM_DATA, {24'h0, d});
    endtask

    task automatic run(input alu_pkg::op_t op, input alu_pkg::mode_t md, input logic [7:0] ad,
                       input logic [7:0] im, input logic [1:0] bl, input logic [3:0] cl,
                       input logic [7:0] ea, input logic [7:0] ep);
        int n;
        xfer(1'b1, alu_pkg::OFS_CMD, {8'h00, im, ad, 1'b0, md, op});
        n = 0;
        do begin
            xfer(1'b0, alu_pkg::OFS_STATUS, 32'h0);
            n++;
        end while (rdat[0] !== 1'b0 && n < 20);
        chk("busy", 32'h0, {31'h0, rdat[0]});
        chk("length", {26'h0, cl, bl}, {26'h0, rdat[7:2]});
        rd("acc", alu_pkg::OFS_ACC, {24'h0, ea});
        rd("psw", alu_pkg::OFS_PSW, {24'h0, ep});
        $display("test op %0d mode %0d done", op, md);
    endtask

    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // whole run is near 400 cycles
    initial begin
        #100000;
        mismatches++;
        close_out;
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("psw reset", alu_pkg::OFS_PSW, 32'h0);
        rd("acc reset", alu_pkg::OFS_ACC, 32'h0);
        // bank 1 holds r0 at 0x08 and r2 at 0x0a
        xfer(1'b1, alu_pkg::OFS_PSW, 32'h08);
        set_ram(8'h0a, 8'h15);
        set_ram(8'h08, 8'h30);
        set_ram(8'h30, 8'h21);
        set_ram(8'h40, 8'h0f);
        xfer(1'b1, alu_pkg::OFS_ACC, 32'h70);
        run(alu_pkg::add_op, alu_pkg::mode_reg, 8'h02, 8'h00, 2'h1, 4'h1, 8'h85, 8'h0d);
        run(alu_pkg::add_op, alu_pkg::mode_direct, 8'h40, 8'h00, 2'h2, 4'h2, 8'h94, 8'h49);
        run(alu_pkg::add_op, alu_pkg::mode_indirect, 8'h00, 8'h00, 2'h1, 4'h2, 8'hb5, 8'h09);
        xfer(1'b1, alu_pkg::OFS_PSW, 32'h88);
        run(alu_pkg::carry_sum_op, alu_pkg::mode_immediate, 8'h00, 8'h4a, 2'h2, 4'h2, 8'h00, 8'hc8);
        run(alu_pkg::borrow_subtract_op, alu_pkg::mode_direct, 8'h40, 8'h00, 2'h2, 4'h2, 8'hf0, 8'hc8);
        run(alu_pkg::borrow_subtract_op, alu_pkg::mode_reg, 8'h02, 8'h00, 2'h1, 4'h1, 8'hda, 8'h49);
        run(alu_pkg::and_op, alu_pkg::mode_direct_imm, 8'h40, 8'h3c, 2'h3, 4'h3, 8'hda, 8'h49);
        run(alu_pkg::xor_op, alu_pkg::mode_direct_imm, 8'h40, 8'hff, 2'h3, 4'h3, 8'hda, 8'h49);
        run(alu_pkg::or_op, alu_pkg::mode_direct_imm, 8'h40, 8'h04, 2'h3, 4'h3, 8'hda, 8'h49);
        xfer(1'b1, alu_pkg::OFS_RAM_PTR, 32'h40);
        rd("direct byte", alu_pkg::OFS_RAM_DATA, 32'hf7);
        for (i = 0; i < 3; i++) begin
            run(lop[i], alu_pkg::mode_indirect, 8'h00, 8'h00, 2'h1, 4'h2, lacc[i], 8'h48);
        end
        run(alu_pkg::xor_op, alu_pkg::mode_direct, 8'h40, 8'h00, 2'h2, 4'h2, 8'hf7, 8'h49);
        run(alu_pkg::xor_op, alu_pkg::mode_direct_acc, 8'h40, 8'h00, 2'h2, 4'h2, 8'hf7, 8'h49);
        rd("direct byte", alu_pkg::OFS_RAM_DATA, 32'h00);
        run(alu_pkg::rotate_left_via_carry, alu_pkg::mode_reg, 8'h00, 8'h00, 2'h1, 4'h1, 8'hee, 8'hc8);
        run(alu_pkg::rotate_left_via_carry, alu_pkg::mode_reg, 8'h00, 8'h00, 2'h1, 4'h1, 8'hdd, 8'hc8);
        xfer(1'b1, alu_pkg::OFS_PSW, 32'h2a);
        run(alu_pkg::add_op, alu_pkg::mode_immediate, 8'h00, 8'h01, 2'h2, 4'h2, 8'hde, 8'h2a);
        run(alu_pkg::and_op, alu_pkg::mode_direct_imm, 8'hd0, 8'h00, 2'h3, 4'h3, 8'hde, 8'h22);
        xfer(1'b1, alu_pkg::OFS_BREG, 32'h02);
        run(alu_pkg::multiply_op, alu_pkg::mode_reg, 8'h00, 8'h00, 2'h1, 4'h4, 8'hbc, 8'h27);
        rd("b high", alu_pkg::OFS_BREG, 32'h01);
        run(alu_pkg::divide_op, alu_pkg::mode_reg, 8'h00, 8'h00, 2'h1, 4'h8, 8'hbc, 8'h23);
        rd("b rem", alu_pkg::OFS_BREG, 32'h00);
        run(alu_pkg::divide_op, alu_pkg::mode_reg, 8'h00, 8'h00, 2'h1, 4'h8, 8'hbc, 8'h27);
        xfer(1'b0, 8'h20, 32'h0);
        chk("unmapped data", 32'h0, rdat);
        chk("unmapped error", 32'h1, {31'h0, perr});
        xfer(1'b1, alu_pkg::OFS_STATUS, 32'hff);
        chk("status write error", 32'h1, {31'h0, perr});
        $display("test refusals done");
        close_out;
    end
endmodule
`default_nettype wire
